// ==== sff_front_end.sv ====
`timescale 1ns/10ps

// small synchronous fifo, count based
module sff_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] store [0:D-1];   // word storage
  logic [AW-1:0] wr_ptr;         // next write slot
  logic [AW-1:0] rd_ptr;         // next read slot
  logic [AW:0]   count;          // words held
  wire           do_push = in_valid & in_ready;
  wire           do_pop  = out_valid & out_ready;

  assign in_ready  = count != (AW+1)'(D);
  assign out_valid = count != '0;
  assign out_data  = store[rd_ptr];

  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (do_push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)  rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// Functional notes
// - works with clock mode 0 or 3
// - opcode decoded only after chip select falls
// - chip select rise ends every operation
// - deselected means standby, never deep power-down
// - output floats while deselected
// - input ignored while deselected
// - running program or erase completes first
// - input bits sampled on rising clock
// - output bits change on falling clock
// - dual read turns input line to output
// - dual read gives two bits per fall
// - program takes 1 to 256 page bytes
// - erase page, 4k, 32k or whole array
// - 128-byte otp, 64 factory, 64 user
// - program/erase outcome checked, failure readable; here only program outcomes set fail, erase never does
// - maker and part identity read back
// - hold ignores clock/input, floats output
module sff_front_end
  import sff_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic hold_n,
  input  wire logic dual_line_low_in,
  output logic      dual_line_low_out,
  output logic      dual_line_low_oe,
  output logic      dual_line_high_out,
  output logic      dual_line_high_oe,
  output logic      standby,
  output logic      busy
);
  typedef enum logic [1:0] {C_OP, C_ADDR, C_DATA, C_SKIP} sff_core_type;

  // ---------------- link side, serial clock ----------------
  wire        link_rst_n = rst_n & ~cs_n;  // frame ends clear link state
  logic       hold_m;        // hold synchroniser, first stage
  logic       hold_q;        // high while not held
  logic [2:0] bit_cnt;       // bit within byte
  logic [2:0] byte_cnt;      // bytes seen, saturates
  logic [7:0] in_sh;         // input shifter
  logic [7:0] link_op;       // first byte of frame
  logic [7:0] rx_byte;       // last whole byte
  logic       rx_tgl;        // flips per byte
  logic [2:0] out_cnt;       // output step within byte
  logic [7:0] out_sh;        // output shifter
  logic       ack_tgl;       // flips per byte taken
  logic [7:0] tx_word;       // next byte from core side
  wire        link_dual  = link_op == OP_DUAL;
  wire [2:0]  data_start = op_has_addr(link_op) ? START_ADDR : START_NONE;
  wire        out_phase  = op_is_reply(link_op) && byte_cnt >= data_start;
  wire [7:0]  next_byte  = {in_sh[6:0], dual_line_low_in};
  wire        out_load   = out_cnt == 3'h0;
  wire [7:0]  out_cur    = out_load ? tx_word : out_sh;

  // hold sampled on falling sck edges, two stages
  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      hold_m <= 1'b1;
      hold_q <= 1'b1;
    end else begin
      hold_m <= hold_n;
      hold_q <= hold_m;
    end
  end

  // input shifting on rising edges, only while selected
  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      in_sh    <= 8'h00;
      link_op  <= 8'h00;
    end else if (hold_q) begin
      in_sh   <= next_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (byte_cnt != 3'h7) byte_cnt <= byte_cnt + 3'h1;
        if (byte_cnt == 3'h0) link_op <= next_byte;
      end
    end
  end

  // byte hand-off; not cleared by the frame so no false event
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= 8'h00;
      rx_tgl  <= 1'b0;
    end else if (hold_q && bit_cnt == 3'h7 && !out_phase) begin
      rx_byte <= next_byte;
      rx_tgl  <= ~rx_tgl;
    end
  end

  // output drive on falling edges; mode 3 first fall does nothing
  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_cnt            <= 3'h0;
      out_sh             <= 8'h00;
      dual_line_high_out <= 1'b0;
      dual_line_high_oe  <= 1'b0;
      dual_line_low_out  <= 1'b0;
      dual_line_low_oe   <= 1'b0;
    end else if (!hold_q) begin
      dual_line_high_oe <= 1'b0;
      dual_line_low_oe  <= 1'b0;
    end else if (out_phase) begin
      dual_line_high_out <= out_cur[7];
      dual_line_high_oe  <= 1'b1;
      if (link_dual) begin
        dual_line_low_out <= out_cur[6];
        dual_line_low_oe  <= 1'b1;
        out_sh            <= {out_cur[5:0], 2'b00};
        out_cnt           <= (out_cnt == 3'h3) ? 3'h0 : out_cnt + 3'h1;
      end else begin
        out_sh  <= {out_cur[6:0], 1'b0};
        out_cnt <= out_cnt + 3'h1;
      end
    end
  end

  // each taken output byte is reported to the core side
  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      ack_tgl <= 1'b0;
    end else if (hold_q && out_phase && out_load) begin
      ack_tgl <= ~ack_tgl;
    end
  end

  // ---------------- core side, system clock ----------------
  logic [2:0] cs_sync;       // chip select, 2 stages plus history
  logic [2:0] rx_sync;       // byte toggle, 2 stages plus history
  logic [2:0] ack_sync;      // ack toggle, 2 stages plus history
  logic       end_pend;      // frame end waiting for fifo room
  logic       ovr;           // byte lost, fifo full
  wire        rx_ev  = rx_sync[1] ^ rx_sync[2];
  wire        ack_ev = ack_sync[1] ^ ack_sync[2];
  wire        cs_rise = cs_sync[1] & ~cs_sync[2];

  // crossings; first stages feed only second stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync  <= 3'h7;
      rx_sync  <= 3'h0;
      ack_sync <= 3'h0;
    end else begin
      cs_sync  <= {cs_sync[1:0], cs_n};
      rx_sync  <= {rx_sync[1:0], rx_tgl};
      ack_sync <= {ack_sync[1:0], ack_tgl};
    end
  end

  // fifo fill: bytes first, frame-end marker after
  wire                fifo_in_valid = rx_ev | end_pend;
  wire                fifo_in_ready;
  wire [FIFO_W-1:0]   fifo_in_data  = rx_ev ? {1'b0, rx_byte} : 9'h100;
  wire                fifo_out_valid;
  wire [FIFO_W-1:0]   fifo_out_data;
  logic [2:0]         prog_wait;   // per-byte program time
  wire                fifo_out_ready = prog_wait == 3'h0;

  sff_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // frame end pending; the set beats the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      end_pend <= 1'b0;
    end else if (cs_rise) begin
      end_pend <= 1'b1;
    end else if (!rx_ev && fifo_in_ready) begin
      end_pend <= 1'b0;
    end
  end

  // core state
  sff_core_type st;
  logic [7:0]   op_c;        // command of this frame
  logic [15:0]  addr;        // byte address
  logic [1:0]   acnt;        // address bytes taken
  logic         need_load;   // first reply byte due
  logic         id_idx;      // identity byte index
  logic         fail;        // last program/erase failed
  logic         er_busy;     // erase walk running
  logic [15:0]  er_addr;     // erase walk position
  logic [15:0]  er_last;     // erase walk end
  logic [63:0]  otp_used;    // user otp bytes programmed
  logic [7:0]   mem  [0:MEM_BYTES-1];  // flash array
  logic [7:0]   otp_user [0:OTP_HALF-1];

  wire        pop     = fifo_out_valid & fifo_out_ready;
  wire        w_end   = fifo_out_data[8];
  wire [7:0]  w       = fifo_out_data[7:0];
  wire [7:0]  mem_rd  = mem[addr];
  wire [5:0]  otp_i   = addr[5:0];
  wire        otp_hi  = addr[6];
  wire [7:0]  otp_rd  = !otp_hi ? (OTP_SEED ^ {2'b00, otp_i}) :
                        otp_used[otp_i] ? otp_user[otp_i] : 8'hff;
  wire        in_data = pop && !w_end && st == C_DATA;
  wire        prog_we = in_data && op_c == OP_PROG;
  wire        otp_we  = in_data && op_c == OP_OTP_PROG && otp_hi;
  wire        otp_bad = in_data && op_c == OP_OTP_PROG && !otp_hi;
  wire [15:0] er_mask = op_c == OP_ER_PAGE ? MASK_PAGE :
                        op_c == OP_ER_4K   ? MASK_4K   :
                        op_c == OP_ER_32K  ? MASK_32K  : MASK_CHIP;
  wire        er_go   = pop && w_end && st == C_DATA &&
                        op_is_erase(op_c) && !er_busy;
  wire        tx_due  = st == C_DATA && op_is_reply(op_c) &&
                        (need_load || ack_ev);
  wire [7:0]  status  = {1'b0, ovr, fail, 4'h0, busy};
  wire [7:0]  id_byte = id_idx ? ID_PART : ID_MAKER;

  // array writes: erase walk or program byte, never both
  always_ff @(posedge clk) begin
    if (er_busy) begin
      mem[er_addr] <= 8'hff;
    end else if (prog_we) begin
      mem[addr] <= mem_rd & w;                    // bits only clear
    end
    if (otp_we) begin
      otp_user[otp_i] <= otp_rd & w;
    end
  end

  // command decoding from the fifo
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= C_OP;
      op_c      <= 8'h00;
      addr      <= 16'h0000;
      acnt      <= 2'h0;
      need_load <= 1'b0;
      id_idx    <= 1'b0;
      tx_word   <= 8'h00;
    end else begin
      if (tx_due) begin                           // reply byte ready
        need_load <= 1'b0;
        case (op_c)
          OP_STATUS: tx_word <= status;
          OP_ID: begin
            tx_word <= id_idx | !need_load ? id_byte : ID_MAKER;
            id_idx  <= 1'b1;
          end
          OP_OTP_READ: begin
            tx_word <= otp_rd;
            addr    <= {9'h000, addr[6:0] + 7'h01};
          end
          default: begin
            tx_word <= mem_rd;
            addr    <= addr + 16'h0001;
          end
        endcase
      end
      if (pop && w_end) begin
        st <= C_OP;
      end else if (pop) begin
        case (st)
          C_OP: begin
            op_c   <= w;
            acnt   <= 2'h0;
            id_idx <= 1'b0;
            if ((er_busy || busy) && w != OP_STATUS) begin
              st <= C_SKIP;
            end else if (op_has_addr(w)) begin
              st <= C_ADDR;
            end else if (op_is_reply(w) || w == OP_ER_CHIP) begin
              st        <= C_DATA;
              need_load <= op_is_reply(w);
            end else begin
              st <= C_SKIP;
            end
          end
          C_ADDR: begin
            addr <= {addr[7:0], w};
            acnt <= acnt + 2'h1;
            if (acnt == 2'h2) begin
              st        <= C_DATA;
              need_load <= op_is_reply(op_c);
            end
          end
          C_DATA: begin
            if (prog_we) begin
              addr <= {addr[15:8], addr[7:0] + 8'h01};
            end else if (op_c == OP_OTP_PROG) begin
              addr <= {9'h000, addr[6:0] + 7'h01};
            end
          end
          default: st <= C_SKIP;
        endcase
      end
    end
  end

  // erase walk, self timed, untouched by chip select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      er_busy <= 1'b0;
      er_addr <= 16'h0000;
      er_last <= 16'h0000;
    end else if (er_go) begin
      er_busy <= 1'b1;
      er_addr <= addr & ~er_mask;
      er_last <= addr | er_mask;
    end else if (er_busy) begin
      er_addr <= er_addr + 16'h0001;
      if (er_addr == er_last) er_busy <= 1'b0;
    end
  end

  // program stall, outcome check, otp usage, lost bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_wait <= 3'h0;
      fail      <= 1'b0;
      otp_used  <= 64'h0;
      ovr       <= 1'b0;
    end else begin
      if (prog_we || otp_we) begin
        prog_wait <= PROG_CYC;
      end else if (prog_wait != 3'h0) begin
        prog_wait <= prog_wait - 3'h1;
      end
      // fail kept until the next program or erase command
      if ((prog_we && (mem_rd & w) != w) ||
          (otp_we && (otp_rd & w) != w) || otp_bad) begin
        fail <= 1'b1;
      end else if (pop && st == C_OP && (w == OP_PROG ||
                   w == OP_OTP_PROG || op_is_erase(w))) begin
        fail <= 1'b0;
      end
      if (otp_we) otp_used[otp_i] <= 1'b1;
      if (rx_ev && !fifo_in_ready) begin
        ovr <= 1'b1;                              // overrun sticky
      end else if (tx_due && op_c == OP_STATUS) begin
        ovr <= 1'b0;
      end
    end
  end

  // standby only once deselected and idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      standby <= 1'b1;
      busy    <= 1'b0;
    end else begin
      busy    <= er_busy | (prog_wait != 3'h0) | er_go;
      // a frame end still in flight may start an erase, so wait it out
      standby <= cs_sync[2] & ~end_pend & ~fifo_out_valid & ~er_busy &
                 ~er_go & (prog_wait == 3'h0);
    end
  end
endmodule

// ==== sff_pkg.sv ====
package sff_pkg;
  // command codes, chosen values
  localparam logic [7:0] OP_READ     = 8'h0b;
  localparam logic [7:0] OP_DUAL     = 8'h3b;
  localparam logic [7:0] OP_PROG     = 8'h02;
  localparam logic [7:0] OP_ER_PAGE  = 8'h81;
  localparam logic [7:0] OP_ER_4K    = 8'h20;
  localparam logic [7:0] OP_ER_32K   = 8'h52;
  localparam logic [7:0] OP_ER_CHIP  = 8'h60;
  localparam logic [7:0] OP_OTP_PROG = 8'h9b;
  localparam logic [7:0] OP_OTP_READ = 8'h77;
  localparam logic [7:0] OP_STATUS   = 8'h05;
  localparam logic [7:0] OP_ID       = 8'h9f;
  // identity bytes, values arbitrary
  localparam logic [7:0] ID_MAKER    = 8'h5a;
  localparam logic [7:0] ID_PART     = 8'h3c;
  localparam logic [7:0] OTP_SEED    = 8'ha5;  // arbitrary serial seed
  // erase granule masks on the 16-bit byte address
  localparam logic [15:0] MASK_PAGE  = 16'h00ff;
  localparam logic [15:0] MASK_4K    = 16'h0fff;
  localparam logic [15:0] MASK_32K   = 16'h7fff;
  localparam logic [15:0] MASK_CHIP  = 16'hffff;
  // sizes and counts
  localparam int          MEM_BYTES  = 65536;
  localparam int          OTP_HALF   = 64;
  localparam int          FIFO_W     = 9;
  localparam int          FIFO_D     = 16;
  localparam logic [2:0]  PROG_CYC   = 3'h7;   // stall cycles per byte
  localparam logic [2:0]  START_ADDR = 3'h5;   // op + 3 addr + dummy
  localparam logic [2:0]  START_NONE = 3'h2;   // op + dummy
  // status byte fields
  localparam int          ST_BUSY    = 0;
  localparam int          ST_FAIL    = 5;
  localparam int          ST_OVR     = 6;

  // commands followed by three address bytes
  function automatic logic op_has_addr(input logic [7:0] op);
    return op == OP_READ || op == OP_DUAL || op == OP_PROG ||
           op == OP_ER_PAGE || op == OP_ER_4K || op == OP_ER_32K ||
           op == OP_OTP_PROG || op == OP_OTP_READ;
  endfunction

  // commands that answer with data after a dummy byte
  function automatic logic op_is_reply(input logic [7:0] op);
    return op == OP_READ || op == OP_DUAL || op == OP_OTP_READ ||
           op == OP_STATUS || op == OP_ID;
  endfunction

  // erase commands
  function automatic logic op_is_erase(input logic [7:0] op);
    return op == OP_ER_PAGE || op == OP_ER_4K || op == OP_ER_32K ||
           op == OP_ER_CHIP;
  endfunction
endpackage

// ==== sff_front_end_chk.sv ====
`timescale 1ns/10ps
// pin-level watcher for the front end
module sff_front_end_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic dual_line_low_in,
  input wire logic dual_line_low_out,
  input wire logic dual_line_low_oe,
  input wire logic dual_line_high_out,
  input wire logic dual_line_high_oe,
  input wire logic standby,
  input wire logic busy
);
  float_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    cs_n |-> !dual_line_high_oe && !dual_line_low_oe)
    else $error("line driven while deselected");
  // a change seen while sck is high means a launch on the wrong edge
  high_fall_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(dual_line_high_out) && !cs_n |-> !sck)
    else $error("high line changed with sck high");
  low_fall_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $changed(dual_line_low_out) && !cs_n |-> !sck)
    else $error("low line changed with sck high");
  dual_pair_a: assert property (
    @(negedge sck) disable iff (!rst_n)
    dual_line_low_oe |-> dual_line_high_oe)
    else $error("low line driven alone");
  // two synchroniser stages plus the enable flop
  hold_float_a: assert property (
    @(negedge sck) disable iff (!rst_n)
    !hold_n [*4] |-> !dual_line_high_oe && !dual_line_low_oe)
    else $error("output driven under hold");
  standby_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cs_n && !busy) [*8] |-> standby)
    else $error("no standby while idle");
  select_wake_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !cs_n [*6] |-> !standby)
    else $error("standby while selected");
  standby_busy_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    busy [*2] |-> !standby)
    else $error("standby during internal cycle");
  reset_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> standby && !busy && !dual_line_high_oe)
    else $error("bad levels after reset");
endmodule

bind sff_front_end sff_front_end_chk u_chk (
  .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
  .dual_line_low_in(dual_line_low_in), .dual_line_low_out(dual_line_low_out),
  .dual_line_low_oe(dual_line_low_oe), .standby(standby), .busy(busy),
  .dual_line_high_out(dual_line_high_out),
  .dual_line_high_oe(dual_line_high_oe)
);

// ==== sff_host.sv ====
`timescale 1ns/10ps
// host spi master, mode 0 or 3, sck can also be clocked outside frames
module sff_host (
  output logic      sck,
  output logic      cs_n,
  output logic      hold_n,
  output logic      si,
  input  wire logic high_out,
  input  wire logic high_oe,
  input  wire logic low_out,
  input  wire logic low_oe
);
  logic mode3;  // set by the bench: sck idles high, fall before rise
  // idle levels; sck low for mode 0
  initial begin
    mode3 = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    si = 1'b0;
  end
  // falling select opens a frame; odd offset keeps off clk edges
  task automatic start();
    sck = mode3; // idle level settled before select falls
    #3 cs_n = 1'b0;
    #160;
  endtask
  // rising select ends it; the gap lets a program stall drain
  task automatic stop();
    #160 cs_n = 1'b1;
    hold_n = 1'b1;
    #320;
  endtask
  // one full sck period, 160 ns
  task automatic pulse();
    #80 sck = 1'b1;
    #80 sck = 1'b0;
  endtask
  // whole byte, msb first, data moved while sck low
  task automatic tx(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      if (mode3) #80 sck = 1'b0;
      si = b[i];
      #80 sck = 1'b1;
      if (!mode3) #80 sck = 1'b0;
    end
  endtask
  // sample just before the rise; undriven lines read as unknown
  task automatic rx(input logic dual, output logic [7:0] b);
    int i;
    i = 7;
    while (i >= 0) begin
      if (mode3) #80 sck = 1'b0;
      si = ~si; // toggled each step, so never a stale level
      #80 b[i] = high_oe ? high_out : 1'bx;
      if (dual) begin
        i--;
        b[i] = low_oe ? low_out : 1'bx;
      end
      i--;
      sck = 1'b1;
      if (!mode3) #80 sck = 1'b0;
    end
  endtask
  // pause with sck low, then keep clocking under hold
  task automatic hold4();
    // moved mid low phase, away from the fall that samples it
    #40 hold_n = 1'b0;
    #40 sck = 1'b1;
    #80 sck = 1'b0;
    repeat (4) pulse();
  endtask
endmodule

// ==== test_serial_flash_spi_front_end.sv ====
`timescale 1ns/10ps
// self-checking bench for the serial front end
module test_serial_flash_spi_front_end
  import sff_pkg::*;
;
  logic clk;         // core clock
  logic rst_n;       // core reset
  wire  sck;         // link clock from host
  wire  cs_n;        // chip select
  wire  hold_n;      // hold
  wire  host_si;     // host drive of the input pin
  wire  lo_in;       // resolved input pin level
  wire  lo_out;      // low line value
  wire  lo_oe;       // low line enable
  wire  hi_out;      // output line value
  wire  hi_oe;       // output line enable
  wire  standby;     // standby flag
  wire  busy;        // internal cycle flag
  int   mismatches;  // failed comparisons
  int   check_count; // all comparisons

  // device wins the shared pin while it drives it
  assign lo_in = lo_oe ? lo_out : host_si;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  sff_front_end u_sff_front_end (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
    .dual_line_low_in(lo_in), .dual_line_low_out(lo_out),
    .dual_line_low_oe(lo_oe), .dual_line_high_out(hi_out),
    .dual_line_high_oe(hi_oe), .standby(standby), .busy(busy)
  );

  sff_host u_sff_host (
    .sck(sck), .cs_n(cs_n), .hold_n(hold_n), .si(host_si),
    .high_out(hi_out), .high_oe(hi_oe), .low_out(lo_out), .low_oe(lo_oe)
  );

  // counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check1(input logic g, input logic e, input string m);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t %s got %b", $time, m, g);
    end
  endtask

  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t byte %h expected %h", $time, g, e);
    end
  endtask

  // bounded wait for the internal cycle to end
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (busy !== 1'b0) begin
      mismatches++;
      $display("[FAIL] %0t busy stuck", $time);
      summarize();
    end
    repeat (10) @(negedge clk);
  endtask

  // opcode plus three address bytes where the command takes them
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    u_sff_host.start();
    u_sff_host.tx(op);
    if (op != OP_STATUS && op != OP_ID && op != OP_ER_CHIP) begin
      u_sff_host.tx(8'h00);
      u_sff_host.tx(a[15:8]);
      u_sff_host.tx(a[7:0]);
    end
  endtask

  // dummy byte, then two reply bytes judged
  task automatic rd2(input logic [7:0] op, input logic [15:0] a,
                     input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] r;
    hdr(op, a);
    u_sff_host.tx(8'h00);
    u_sff_host.rx(op == OP_DUAL, r);
    check8(r, e0);
    u_sff_host.rx(op == OP_DUAL, r);
    check8(r, e1);
    u_sff_host.stop();
  endtask

  task automatic pg(input logic [7:0] op, input logic [15:0] a,
                    input int n, input logic [7:0] d0, input logic [7:0] d1);
    hdr(op, a);
    u_sff_host.tx(d0);
    if (n > 1) begin
      u_sff_host.tx(d1);
    end
    u_sff_host.stop();
    wait_idle();
  endtask

  // erase runs after select rises; no standby until done
  task automatic ers(input logic [7:0] op, input logic [15:0] a);
    hdr(op, a);
    u_sff_host.stop();
    check1(busy, 1'b1, "erase not started");
    check1(standby, 1'b0, "standby mid erase");
    wait_idle();
    check1(standby, 1'b1, "no standby after erase");
  endtask

  // reset levels; clocking with select high must do nothing
  task automatic s_idle();
    check1(standby, 1'b1, "standby after reset");
    check1(hi_oe, 1'b0, "driven after reset");
    u_sff_host.tx(OP_ER_CHIP);
    repeat (40) @(negedge clk);
    check1(busy, 1'b0, "deselected erase ran");
    rd2(OP_STATUS, 16'h0000, 8'h00, 8'h00);
  endtask

  task automatic s_ident();
    rd2(OP_ID, 16'h0000, ID_MAKER, ID_PART);
    check1(hi_oe, 1'b0, "driven after frame");
  endtask

  // program with page wrap, fail report, erase granules
  task automatic s_prog();
    ers(OP_ER_4K, 16'h0abc);
    pg(OP_PROG, 16'h01ff, 2, 8'ha1, 8'hb2);
    pg(OP_PROG, 16'h0200, 1, 8'h5c, 8'h00);
    rd2(OP_READ, 16'h01ff, 8'ha1, 8'h5c);
    rd2(OP_READ, 16'h0100, 8'hb2, 8'hff);
    rd2(OP_DUAL, 16'h01ff, 8'ha1, 8'h5c);
    u_sff_host.mode3 = 1'b1;
    rd2(OP_READ, 16'h0100, 8'hb2, 8'hff);
    rd2(OP_DUAL, 16'h0200, 8'h5c, 8'hff);
    u_sff_host.mode3 = 1'b0;
    rd2(OP_STATUS, 16'h0000, 8'h00, 8'h00);
    pg(OP_PROG, 16'h01ff, 1, 8'hff, 8'h00);
    rd2(OP_STATUS, 16'h0000, 8'h20, 8'h20);
    ers(OP_ER_PAGE, 16'h0180);
    rd2(OP_READ, 16'h01ff, 8'hff, 8'h5c);
    rd2(OP_STATUS, 16'h0000, 8'h00, 8'h00);
    ers(OP_ER_32K, 16'h1234);
    rd2(OP_READ, 16'h01ff, 8'hff, 8'hff);
  endtask

  task automatic s_otp();
    rd2(OP_OTP_READ, 16'h003e, OTP_SEED^8'h3e, OTP_SEED^8'h3f);
    rd2(OP_OTP_READ, 16'h007f, 8'hff, OTP_SEED);
    pg(OP_OTP_PROG, 16'h0040, 1, 8'h3c, 8'h00);
    rd2(OP_OTP_READ, 16'h003f, OTP_SEED^8'h3f, 8'h3c);
    pg(OP_OTP_PROG, 16'h0000, 1, 8'h00, 8'h00);
    rd2(OP_STATUS, 16'h0000, 8'h20, 8'h20);
  endtask

  task automatic s_hold();
    hdr(OP_ID, 16'h0000);
    u_sff_host.tx(8'h00);
    u_sff_host.hold4();
    check1(hi_oe, 1'b0, "driven under hold");
    u_sff_host.stop();
  endtask

  // chip erase left running; only status is answered meanwhile
  task automatic s_chip();
    hdr(OP_ER_CHIP, 16'h0000);
    u_sff_host.stop();
    check1(busy, 1'b1, "chip erase idle");
    check1(standby, 1'b0, "standby mid erase");
    rd2(OP_STATUS, 16'h0000, 8'h01, 8'h01);
  endtask

  initial begin
    mismatches = 0;
    check_count = 0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    s_idle();
    s_ident();
    s_prog();
    s_otp();
    s_hold();
    s_chip();
    summarize();
  end
endmodule
